// *** inc/clig_pkg.sv ***
package clig_pkg;

  localparam int          NUM_LEVELS          = 6;
  localparam int          DATA_W              = 16;
  localparam int          PC_W                = 16;

  // Data-memory addresses of the two mapped registers
  localparam logic [15:0] LEVEL_MASK_ADDR     = 16'h0004;
  localparam logic [15:0] LEVEL_PENDING_ADDR  = 16'h0006;

  // Field layout: levels one to six sit in bits 0..5, the rest reads zero
  localparam int          LEVEL_LSB           = 0;
  localparam int          LEVEL_MSB           = 5;
  localparam logic [5:0]  LEVEL_MASK_RESET    = 6'h00;
  localparam logic [5:0]  LEVEL_PENDING_RESET = 6'h00;

  // Status register zero: global disable bit position and reset value
  localparam int          GDIS_BIT            = 9;
  localparam logic [15:0] STATUS_ZERO_RESET   = 16'h0200;

  // Fixed vectors outside the maskable levels
  localparam logic [15:0] NMI_VECTOR          = 16'h0024;
  localparam logic [15:0] TRAP_VECTOR         = 16'h0022;

  // Base encoding of the soft interrupt opcode; number goes in the low five bits
  localparam logic [15:0] SOFT_IRQ_OPCODE     = 16'hbe60;
  localparam logic [15:0] SOFT_IRQ_NUM_MASK   = 16'h001f;

  // Hardware return-address stack
  localparam int          STACK_DEPTH         = 8;
  localparam int          STACK_AW            = 3;

  typedef enum logic [3:0]
  {
    ST_IDLE = 4'b0001,
    ST_JAM  = 4'b0010,
    ST_PUSH = 4'b0100,
    ST_LOAD = 4'b1000
  } clig_state_t;

  typedef enum logic [3:0]
  {
    SRC_HW   = 4'b0001,
    SRC_SOFT = 4'b0010,
    SRC_TRAP = 4'b0100,
    SRC_NMI  = 4'b1000
  } clig_src_t;

endpackage

// *** inc/clig_stack_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface clig_stack_if;
  logic                      push;
  logic                      pop;
  logic [clig_pkg::PC_W-1:0] push_data;
  logic [clig_pkg::PC_W-1:0] pop_data;
  logic                      pop_valid;
  logic                      empty;

  modport ctrl
  (
    output push,
    output pop,
    output push_data,
    input  pop_data,
    input  pop_valid,
    input  empty
  );

  modport mem
  (
    input  push,
    input  pop,
    input  push_data,
    output pop_data,
    output pop_valid,
    output empty
  );
endinterface

`default_nettype wire

// *** design/clig_stack.sv ***
`timescale 1ns/1ps
`default_nettype none

module clig_stack
(
  input wire logic   clk,
  input wire logic   rst_sync_n,
  clig_stack_if.mem  stk
);

  logic [clig_pkg::PC_W-1:0]     mem [clig_pkg::STACK_DEPTH];
  logic [clig_pkg::STACK_AW-1:0] wr_ptr;
  logic [clig_pkg::STACK_AW:0]   count;
  logic [clig_pkg::PC_W-1:0]     rd_data;
  logic                          rd_valid;

  wire  [clig_pkg::STACK_AW-1:0] top_idx  = wr_ptr - 3'h1;
  wire                           is_full  = (count == 4'(clig_pkg::STACK_DEPTH));
  wire                           is_empty = (count == 4'h0);

  // Storage has no reset; the pointer, count and read data and valid registers get a defined start
  always_ff @(posedge clk)
  begin
    if (stk.push)
      mem[wr_ptr] <= stk.push_data;
  end

  // A push into a full stack wraps and silently loses the oldest entry
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      wr_ptr   <= '0;
      count    <= '0;
      rd_data  <= '0;
      rd_valid <= 1'b0;
    end
    else
    begin
      rd_valid <= 1'b0;
      if (stk.push)
      begin
        wr_ptr <= wr_ptr + 3'h1;
        if (!is_full)
          count <= count + 4'h1;
      end
      else if (stk.pop)
      begin
        rd_data  <= mem[top_idx];
        rd_valid <= 1'b1;
        if (!is_empty)
        begin
          wr_ptr <= top_idx;
          count  <= count - 4'h1;
        end
      end
    end
  end

  assign stk.pop_data  = rd_data;
  assign stk.pop_valid = rd_valid;
  assign stk.empty     = is_empty;

endmodule

`default_nettype wire

// *** design/clig_gate.sv ***
`timescale 1ns/1ps
`default_nettype none

module clig_gate
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] dm_addr,
  input  wire logic        dm_write_en,
  input  wire logic        dm_read_en,
  input  wire logic [15:0] dm_wdata,
  output logic      [15:0] dm_rdata,
  output logic             dm_rdata_valid,
  input  wire logic [5:0]  src_flag,
  input  wire logic [5:0]  src_enable,
  input  wire logic        instr_boundary,
  input  wire logic        soft_irq_instr,
  input  wire logic [4:0]  soft_irq_num,
  input  wire logic        trap_instr,
  input  wire logic        nmi_pin,
  input  wire logic        set_control_bit_instr,
  input  wire logic        clear_control_bit_instr,
  input  wire logic        load_status_instr,
  input  wire logic [15:0] load_status_data,
  input  wire logic [15:0] cur_pc,
  input  wire logic        ret_instr,
  output logic             instr_bus_force,
  output logic      [15:0] forced_opcode,
  output logic             pc_load,
  output logic      [15:0] pc_vector,
  output logic             ret_pc_valid,
  output logic      [15:0] ret_pc,
  output logic      [5:0]  level_pending_flags,
  output logic      [5:0]  level_mask,
  output logic      [15:0] status_reg_zero,
  output logic             ack_busy
);

  // Vector of a numbered interrupt: two words apart
  function automatic logic [15:0] vector_of(input logic [4:0] num);
    vector_of = {10'h000, num, 1'b0};
  endfunction

  // Index of the lowest set bit, plus one; zero when none is set
  function automatic logic [2:0] first_level(input logic [5:0] req);
    first_level = 3'h0;
    for (int i = clig_pkg::NUM_LEVELS - 1; i >= 0; i--)
      if (req[i])
        first_level = 3'(i + 1);
  endfunction

  function automatic logic [5:0] level_bit(input logic [2:0] num);
    level_bit = (num == 3'h0) ? 6'h00 : 6'(6'h01 << (num - 3'h1));
  endfunction

  // Reset release through two flops
  logic rst_meta_n;
  logic rst_sync_n;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // Pin synchroniser; the edge detector only looks at the second stage
  logic nmi_meta;
  logic nmi_sync;
  logic nmi_prev;
  logic nmi_latched;

  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      nmi_meta <= 1'b0;
      nmi_sync <= 1'b0;
      nmi_prev <= 1'b0;
    end
    else
    begin
      nmi_meta <= nmi_pin;
      nmi_sync <= nmi_meta;
      nmi_prev <= nmi_sync;
    end
  end

  wire nmi_edge = nmi_sync & ~nmi_prev;

  clig_pkg::clig_state_t state;
  clig_pkg::clig_state_t next_state;
  clig_pkg::clig_src_t   cur_src;
  logic [15:0]           saved_pc;
  logic [5:0]            pending;
  logic [5:0]            mask;
  logic [15:0]           status_zero;

  wire gdis = status_zero[clig_pkg::GDIS_BIT];

  // Register decode
  wire sel_mask    = (dm_addr == clig_pkg::LEVEL_MASK_ADDR);
  wire sel_pending = (dm_addr == clig_pkg::LEVEL_PENDING_ADDR);
  wire wr_mask     = dm_write_en & sel_mask;
  wire wr_pending  = dm_write_en & sel_pending;

  wire [5:0] w1c_clear = wr_pending ? dm_wdata[clig_pkg::LEVEL_MSB:clig_pkg::LEVEL_LSB] : 6'h00;
  wire [5:0] level_set = src_flag & src_enable;

  // Mask and global disable both gate; disable only applies to maskable levels
  wire [5:0] eligible   = pending & mask & {clig_pkg::NUM_LEVELS{~gdis}};
  wire [2:0] win_level  = first_level(eligible);
  wire       idle       = (state == clig_pkg::ST_IDLE);

  // NMI and instruction requests bypass mask and disable entirely
  wire take_nmi  = idle & nmi_latched;
  wire take_soft = idle & ~nmi_latched & soft_irq_instr;
  wire take_trap = idle & ~nmi_latched & ~soft_irq_instr & trap_instr;
  wire take_hw   = idle & ~nmi_latched & ~soft_irq_instr & ~trap_instr
                 & instr_boundary & (win_level != 3'h0);
  wire accept    = take_nmi | take_soft | take_trap | take_hw;

  // Only a hardware level acknowledge drops its own pending bit
  wire [5:0] ack_clear = take_hw ? level_bit(win_level) : 6'h00;

  // Set wins over both kinds of clear
  wire [5:0] next_pending = (pending & ~w1c_clear & ~ack_clear) | level_set;

  wire [15:0] accept_vector = take_nmi  ? clig_pkg::NMI_VECTOR :
                              take_trap ? clig_pkg::TRAP_VECTOR :
                              take_soft ? vector_of(soft_irq_num) :
                                          vector_of({2'b00, win_level});

  wire [15:0] accept_opcode = clig_pkg::SOFT_IRQ_OPCODE
                            | (take_soft ? {11'h000, soft_irq_num} : {13'h0000, win_level});

  // Status zero: a non-trap acknowledge or set-control sets the disable bit, and either beats clear-control
  wire set_gdis = (accept & ~take_trap) | set_control_bit_instr;
  logic next_gdis;

  always_comb
  begin
    next_gdis = gdis;
    if (set_gdis)
      next_gdis = 1'b1;
    else if (clear_control_bit_instr)
      next_gdis = 1'b0;
  end

  wire [15:0] loaded_status = load_status_instr ? load_status_data : status_zero;
  // Load-status keeps the current disable bit
  wire [15:0] next_status_zero = {loaded_status[15:clig_pkg::GDIS_BIT+1], next_gdis,
                                  loaded_status[clig_pkg::GDIS_BIT-1:0]};

  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      nmi_latched <= 1'b0;
    else
      nmi_latched <= nmi_edge | (nmi_latched & ~take_nmi);
  end

  // Disable bit lives apart from mask and pending; nothing here writes across
  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      pending     <= clig_pkg::LEVEL_PENDING_RESET;
      mask        <= clig_pkg::LEVEL_MASK_RESET;
      status_zero <= clig_pkg::STATUS_ZERO_RESET;
    end
    else
    begin
      pending     <= next_pending;
      status_zero <= next_status_zero;
      if (wr_mask)
        mask <= dm_wdata[clig_pkg::LEVEL_MSB:clig_pkg::LEVEL_LSB];
    end
  end

  // Read port: one cycle latency, unmapped addresses return zero
  wire [15:0] read_mux = sel_mask    ? {10'h000, mask} :
                         sel_pending ? {10'h000, pending} :
                                       16'h0000;

  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      dm_rdata       <= 16'h0000;
      dm_rdata_valid <= 1'b0;
    end
    else
    begin
      dm_rdata_valid <= dm_read_en;
      if (dm_read_en)
        dm_rdata <= read_mux;
    end
  end

  // Acknowledge sequence: jam opcode, push return address, load vector
  always_comb
  begin
    next_state = state;
    case (state)
      clig_pkg::ST_IDLE:
      begin
        if (accept)
          next_state = clig_pkg::ST_JAM;
      end
      clig_pkg::ST_JAM:
        next_state = clig_pkg::ST_PUSH;
      clig_pkg::ST_PUSH:
        next_state = clig_pkg::ST_LOAD;
      clig_pkg::ST_LOAD:
        next_state = clig_pkg::ST_IDLE;
      default:
        next_state = clig_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      state         <= clig_pkg::ST_IDLE;
      cur_src       <= clig_pkg::SRC_HW;
      forced_opcode <= 16'h0000;
      pc_vector     <= 16'h0000;
      saved_pc      <= 16'h0000;
    end
    else
    begin
      state <= next_state;
      if (accept)
      begin
        pc_vector     <= accept_vector;
        forced_opcode <= accept_opcode;
        saved_pc      <= cur_pc;
        cur_src       <= take_nmi  ? clig_pkg::SRC_NMI :
                         take_soft ? clig_pkg::SRC_SOFT :
                         take_trap ? clig_pkg::SRC_TRAP : clig_pkg::SRC_HW;
      end
    end
  end

  clig_stack_if stk ();

  // Only a hardware level needs the opcode forced; instructions already carry it
  assign instr_bus_force = (state == clig_pkg::ST_JAM) & (cur_src == clig_pkg::SRC_HW);
  assign stk.push        = (state == clig_pkg::ST_PUSH);
  assign stk.push_data   = saved_pc;
  assign stk.pop         = ret_instr & idle;
  assign pc_load         = (state == clig_pkg::ST_LOAD);

  clig_stack u_stack
  (
    .clk        (sys_clk),
    .rst_sync_n (rst_sync_n),
    .stk        (stk)
  );

  assign ret_pc_valid        = stk.pop_valid;
  assign ret_pc              = stk.pop_data;
  assign level_pending_flags = pending;
  assign level_mask          = mask;
  assign status_reg_zero     = status_zero;
  assign ack_busy            = ~idle;

endmodule

`default_nettype wire

// *** testbench/clig_src_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module clig_src_model
(
  input  wire logic       sys_clk,
  input  wire logic [5:0] raise,
  input  wire logic [5:0] sw_clear,
  output logic      [5:0] src_flag = 6'h00,
  output logic      [5:0] src_enable = 6'h00
);
  // Flags stay set until software clears them
  always_ff @(posedge sys_clk)
  begin
    src_flag <= (src_flag | raise) & ~sw_clear;
  end

  // One forward per new event, so a held flag cannot re-arm the level
  always_ff @(posedge sys_clk)
  begin
    src_enable <= raise & ~src_flag;
  end
endmodule

`default_nettype wire

// *** testbench/clig_gate_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none

module clig_gate_asserts
(
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic [15:0] dm_addr,
  input wire logic        dm_write_en,
  input wire logic        dm_read_en,
  input wire logic [15:0] dm_wdata,
  input wire logic [15:0] dm_rdata,
  input wire logic        dm_rdata_valid,
  input wire logic [5:0]  src_flag,
  input wire logic [5:0]  src_enable,
  input wire logic        set_control_bit_instr,
  input wire logic        clear_control_bit_instr,
  input wire logic        load_status_instr,
  input wire logic        instr_bus_force,
  input wire logic [15:0] forced_opcode,
  input wire logic        pc_load,
  input wire logic [15:0] pc_vector,
  input wire logic [5:0]  level_pending_flags,
  input wire logic [5:0]  level_mask,
  input wire logic [15:0] status_reg_zero,
  input wire logic        ack_busy
);
  logic [5:0] req;
  logic [5:0] ready;
  logic [5:0] hw_bit;
  assign req    = src_flag & src_enable;
  assign ready  = level_mask & level_pending_flags;
  assign hw_bit = 6'h01 << (forced_opcode[2:0] - 3'h1);

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  a_read_pending: assert property
    (dm_read_en && dm_addr == 16'h0006 |=> dm_rdata_valid && dm_rdata == {10'h000, $past(level_pending_flags)})
    else $error("pending read wrong");
  a_pend_set: assert property
    (|req |=> (level_pending_flags & $past(req)) == $past(req))
    else $error("request not latched");
  a_pend_cause: assert property
    ((level_pending_flags & ~$past(level_pending_flags) & ~$past(req)) == 6'h00)
    else $error("pending set without request");
  a_w1c_clear: assert property
    (dm_write_en && dm_addr == 16'h0006 |=> (level_pending_flags & $past(dm_wdata[5:0]) & ~$past(req)) == 6'h00)
    else $error("pending not cleared by write");
  a_hw_eligible: assert property
    (instr_bus_force |-> ($past(ready) & hw_bit) != 6'h00 && !$past(status_reg_zero[9]) && status_reg_zero[9])
    else $error("level taken while not eligible");
  a_hw_priority: assert property
    (instr_bus_force |-> ($past(ready) & (hw_bit - 6'h01)) == 6'h00 && pc_vector == {11'h000, forced_opcode[3:0], 1'b0})
    else $error("wrong level or vector");
  a_ack_order: assert property
    ($rose(ack_busy) |-> !pc_load ##1 !pc_load ##1 pc_load ##1 !ack_busy)
    else $error("acknowledge steps out of order");
  a_set_disable: assert property
    (set_control_bit_instr |=> status_reg_zero[9])
    else $error("disable bit not set");
  a_load_keeps: assert property
    (load_status_instr && !set_control_bit_instr && !clear_control_bit_instr |=> ack_busy || $stable(status_reg_zero[9]))
    else $error("status load moved disable bit");
  a_gdis_mask: assert property
    ($changed(status_reg_zero[9]) |-> $stable(level_mask))
    else $error("mask moved with disable bit");
endmodule

`default_nettype wire

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam logic [15:0] MASK = clig_pkg::LEVEL_MASK_ADDR;
  localparam logic [15:0] PEND = clig_pkg::LEVEL_PENDING_ADDR;
  localparam logic [5:0]  P_SOFT = 6'h20;
  localparam logic [5:0]  P_TRAP = 6'h10;
  localparam logic [5:0]  P_DIS = 6'h08;
  localparam logic [5:0]  P_ENA = 6'h04;
  localparam logic [5:0]  P_LOAD = 6'h02;
  localparam logic [5:0]  P_RET = 6'h01;
  logic             sys_clk = 1'b0;
  logic             rst_n = 1'b0;
  logic [15:0]      dm_addr = 16'h0000;
  logic             dm_write_en = 1'b0;
  logic             dm_read_en = 1'b0;
  logic [15:0]      dm_wdata = 16'h0000;
  logic             instr_boundary = 1'b1;
  logic [4:0]       soft_irq_num = 5'h00;
  logic             nmi_pin = 1'b0;
  logic [15:0]      load_status_data = 16'h0000;
  logic [15:0]      cur_pc = 16'h0000;
  logic [5:0]       ctl = 6'h00;
  logic [5:0]       raise = 6'h00;
  logic [5:0]       sw_clear = 6'h00;
  logic [5:0]       pend;
  wire logic        soft_irq_instr, trap_instr, set_control_bit_instr, clear_control_bit_instr;
  wire logic        load_status_instr, ret_instr, dm_rdata_valid, instr_bus_force, pc_load, ret_pc_valid, ack_busy;
  wire logic [15:0] dm_rdata, forced_opcode, pc_vector, ret_pc, status_reg_zero;
  wire logic [5:0]  level_pending_flags, level_mask, src_flag, src_enable;
  wire logic [15:0] gdis = {15'h0000, status_reg_zero[9]};
  int               err_total = 0;
  int               num_checks = 0;
  int               lv [3] = '{2, 3, 5};

  assign {soft_irq_instr, trap_instr, set_control_bit_instr, clear_control_bit_instr, load_status_instr, ret_instr} = ctl;

  clig_gate clig_gate_i (.sys_clk, .rst_n, .dm_addr, .dm_write_en, .dm_read_en, .dm_wdata, .dm_rdata,
    .dm_rdata_valid, .src_flag, .src_enable, .instr_boundary, .soft_irq_instr, .soft_irq_num, .trap_instr,
    .nmi_pin, .set_control_bit_instr, .clear_control_bit_instr, .load_status_instr, .load_status_data, .cur_pc,
    .ret_instr, .instr_bus_force, .forced_opcode, .pc_load, .pc_vector, .ret_pc_valid, .ret_pc,
    .level_pending_flags, .level_mask, .status_reg_zero, .ack_busy);

  clig_src_model clig_src_model_i (.sys_clk, .raise, .sw_clear, .src_flag, .src_enable);

  initial
  begin
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    dm_addr <= a;
    dm_wdata <= d;
    dm_write_en <= 1'b1;
    @(posedge sys_clk);
    dm_write_en <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] exp, input string nm);
    @(posedge sys_clk);
    dm_addr <= a;
    dm_read_en <= 1'b1;
    @(posedge sys_clk);
    dm_read_en <= 1'b0;
    #1;
    chk(nm, exp, dm_rdata);
  endtask

  task automatic pulse(input logic [5:0] v);
    @(posedge sys_clk);
    ctl <= v;
    @(posedge sys_clk);
    ctl <= 6'h00;
  endtask

  task automatic src(input logic [5:0] r, input logic [5:0] c);
    @(posedge sys_clk);
    raise <= r;
    sw_clear <= c;
    @(posedge sys_clk);
    raise <= 6'h00;
    sw_clear <= 6'h00;
  endtask

  // Bounded wait for accept, then vector, jam flag and load step
  task automatic wait_ack(input logic [15:0] vec, input logic frc);
    int n;
    n = 0;
    #1;
    while (ack_busy !== 1'b1 && n < 30)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (ack_busy !== 1'b1)
    begin
      err_total++;
      $display("Error ack_busy expected 1 seen timeout");
      stop_test();
    end
    chk("vector", vec, pc_vector);
    chk("force", {15'h0000, frc}, {15'h0000, instr_bus_force});
    repeat (2) @(posedge sys_clk);
    #1;
    chk("pc_load", 16'h0001, {15'h0000, pc_load});
  endtask

  initial
  begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(MASK, 16'h0000, "mask");
    rd(PEND, 16'h0000, "pending");
    chk("gdis", 16'h0001, gdis);
    wr(MASK, 16'hffff);
    rd(MASK, 16'h003f, "mask");
    rd(16'h0005, 16'h0000, "unmapped");
    wr(MASK, 16'h0000);
    src(6'h25, 6'h00);
    rd(PEND, 16'h0025, "pending");
    wr(PEND, 16'h0004);
    rd(PEND, 16'h0021, "pending");
    wr(PEND, 16'h0021);
    rd(PEND, 16'h0000, "pending");
    src(6'h00, 6'h25);
    // New request and software clear land on the same edge
    fork
      src(6'h01, 6'h00);
      begin
        @(posedge sys_clk);
        wr(PEND, 16'h0001);
      end
    join
    rd(PEND, 16'h0001, "pending");
    wr(PEND, 16'h0001);
    src(6'h04, 6'h01);
    $display("test registers done");
    pulse(P_ENA);
    repeat (6) @(posedge sys_clk);
    #1;
    chk("busy", 16'h0000, {15'h0000, ack_busy});
    chk("gdis", 16'h0000, gdis);
    rd(PEND, 16'h0004, "pending");
    @(posedge sys_clk);
    load_status_data <= 16'hffff;
    pulse(P_LOAD);
    #1;
    chk("gdis", 16'h0000, gdis);
    $display("test masking done");
    pulse(P_DIS);
    wr(MASK, 16'h003f);
    src(6'h12, 6'h00);
    pend = 6'h16;
    for (int i = 0; i < 3; i++)
    begin
      @(posedge sys_clk);
      cur_pc <= 16'h1000 + 16'(lv[i]);
      instr_boundary <= (i != 0);
      pulse(P_ENA);
      if (i == 0)
      begin
        repeat (3) @(posedge sys_clk);
        #1;
        chk("busy", 16'h0000, {15'h0000, ack_busy});
        @(posedge sys_clk);
        instr_boundary <= 1'b1;
      end
      wait_ack(16'(2 * lv[i]), 1'b1);
      chk("opcode", clig_pkg::SOFT_IRQ_OPCODE | 16'(lv[i]), forced_opcode);
      chk("gdis", 16'h0001, gdis);
      pend = pend & ~(6'h01 << (lv[i] - 1));
      chk("pending", {10'h000, pend}, {10'h000, level_pending_flags});
      chk("src_flag", 16'h0001, {15'h0000, src_flag[lv[i] - 1]});
    end
    src(6'h00, 6'h3f);
    $display("test levels done");
    src(6'h04, 6'h00);
    @(posedge sys_clk);
    cur_pc <= 16'h2345;
    soft_irq_num <= 5'h03;
    pulse(P_SOFT);
    wait_ack(16'h0006, 1'b0);
    chk("pending", 16'h0004, {10'h000, level_pending_flags});
    pulse(P_RET);
    #1;
    chk("ret_pc", 16'h2345, ret_pc);
    chk("ret_pc_valid", 16'h0001, {15'h0000, ret_pc_valid});
    wr(PEND, 16'h0004);
    src(6'h00, 6'h3f);
    pulse(P_ENA);
    pulse(P_TRAP);
    wait_ack(clig_pkg::TRAP_VECTOR, 1'b0);
    chk("gdis", 16'h0000, gdis);
    wr(MASK, 16'h0000);
    pulse(P_ENA);
    @(posedge sys_clk);
    nmi_pin <= 1'b1;
    wait_ack(clig_pkg::NMI_VECTOR, 1'b0);
    chk("gdis", 16'h0001, gdis);
    @(posedge sys_clk);
    nmi_pin <= 1'b0;
    $display("test soft trap nmi done");
    wr(MASK, 16'h0015);
    src(6'h08, 6'h00);
    pulse(P_ENA);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(PEND, 16'h0000, "pending");
    rd(MASK, 16'h0000, "mask");
    chk("gdis", 16'h0001, gdis);
    src(6'h00, 6'h3f);
    $display("test reset done");
    stop_test();
  end
endmodule

bind clig_gate clig_gate_asserts clig_gate_asserts_i (.sys_clk, .rst_n, .dm_addr, .dm_write_en, .dm_read_en,
  .dm_wdata, .dm_rdata, .dm_rdata_valid, .src_flag, .src_enable, .set_control_bit_instr, .clear_control_bit_instr,
  .load_status_instr, .instr_bus_force, .forced_opcode, .pc_load, .pc_vector, .level_pending_flags, .level_mask,
  .status_reg_zero, .ack_busy);

`default_nettype wire
